// [design/ddi_pkg.sv]
// Package for the converter data and interrupt register block.
// Assumes one 100 MHz clock and an APB slave with 32-bit data.
package ddi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_SECOND = 8'h01;
  localparam logic [7:0] IDX_EVENT_CONTROL = 8'h02;
  localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h04;
  localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h05;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h06;
  localparam logic [7:0] IDX_SYNC_STATUS = 8'h07;
  localparam logic [7:0] IDX_CONVERSION_VALUE = 8'h08;
  localparam logic [7:0] IDX_CONVERSION_VALUE_BUFFER = 8'h0C;
  // Field positions
  localparam int LEFT_ALIGN_BIT = 2;
  localparam int START_EVENT_BIT = 0;
  localparam int EMPTY_EVENT_BIT = 1;
  localparam int SYNC_BUSY_BIT = 7;
  localparam int CODE_WIDTH = 10;
  localparam int LEFT_CODE_LSB = 6;
  // Reset values
  localparam logic [7:0] RESET_REG8 = 8'h00;
  localparam logic [15:0] RESET_VALUE16 = 16'h0000;
  // Timing of the clock-domain synchronisation
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_TIME_NS = 30;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Interrupt bits: [2] sync ready, [1] buffer empty, [0] underrun
  typedef struct packed {
    logic sync_done_irq;
    logic empty;
    logic underrun;
  } ddi_irq_t;
  // Pending synchronised write
  typedef struct packed {
    logic toBuffer;
    logic [15:0] value;
  } ddi_pend_t;
  typedef enum logic [1:0] {
    SY_IDLE = 2'b00,
    SY_WAIT = 2'b01,
    SY_DONE = 2'b11
  } ddi_sync_t;
endpackage : ddi_pkg

// [design/ddi_top.sv]
// Converter data, buffer and interrupt registers behind an APB slave.
// Assumes start events are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ddi_top #(
  parameter int SYNC_COUNT = ddi_pkg::SYNC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic peripheral_write_guard,
  input wire logic startEvent,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ddi_pkg::CODE_WIDTH-1:0] dacCode,
  output logic conversionStart,
  output logic emptyEvent,
  output logic irq
);
  import ddi_pkg::*;

  logic [7:0] controlSecond;
  logic [1:0] eventControl;
  ddi_irq_t irqEnable;
  ddi_irq_t irqFlags;
  logic [15:0] convValue;
  logic [15:0] bufValue;
  logic bufFull;
  ddi_pend_t pend;
  ddi_sync_t syncState;
  logic [7:0] syncCnt;
  logic sync_in_progress;
  logic [7:0] regIdx;
  logic addrOk;
  logic guarded;
  logic syncWrite;
  logic access;
  logic wrDone;
  logic startTaken;
  logic moveNow;
  logic bufCommit;
  logic dataCommit;

  // Pick the ten-bit code out of a 16-bit value by alignment
  function automatic logic [CODE_WIDTH-1:0] pickCode(input logic [15:0] v, input logic left);
    pickCode = left ? v[15:LEFT_CODE_LSB] : v[CODE_WIDTH-1:0];
  endfunction : pickCode

  // Address decode: word index; nonzero paddr[1:0] or paddr[11:10] is refused
  assign regIdx = paddr[9:2];
  assign addrOk = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                  (regIdx == IDX_CONTROL_SECOND || regIdx == IDX_EVENT_CONTROL ||
                   regIdx == IDX_IRQ_ENABLE_CLEAR || regIdx == IDX_IRQ_ENABLE_SET ||
                   regIdx == IDX_IRQ_FLAGS || regIdx == IDX_SYNC_STATUS ||
                   regIdx == IDX_CONVERSION_VALUE || regIdx == IDX_CONVERSION_VALUE_BUFFER);
  // Buffer is the one register the write guard does not cover
  assign guarded = peripheral_write_guard && regIdx != IDX_CONVERSION_VALUE_BUFFER;
  assign syncWrite = pwrite && (regIdx == IDX_CONVERSION_VALUE ||
                                regIdx == IDX_CONVERSION_VALUE_BUFFER);
  assign access = psel && penable;
  // Write lands at the edge where the master sees pready
  assign wrDone = access && pready && pwrite && addrOk && !pslverr;
  assign sync_in_progress = (syncState != SY_IDLE);
  assign bufCommit = (syncState == SY_DONE) && pend.toBuffer;
  assign dataCommit = (syncState == SY_DONE) && !pend.toBuffer;
  assign startTaken = startEvent && eventControl[START_EVENT_BIT];
  assign moveNow = startTaken && bufFull;

  // APB answer; a synchronised write waits while an earlier one is busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !(syncWrite && sync_in_progress)) begin
      pready <= 1'b1;
      pslverr <= !addrOk || (pwrite && guarded);
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (regIdx)
          IDX_CONTROL_SECOND: prdata <= {24'h00_0000, controlSecond};
          IDX_EVENT_CONTROL: prdata <= {30'h0000_0000, eventControl};
          IDX_IRQ_ENABLE_CLEAR, IDX_IRQ_ENABLE_SET: prdata <= {29'h0000_0000, irqEnable};
          IDX_IRQ_FLAGS: prdata <= {29'h0000_0000, irqFlags};
          IDX_SYNC_STATUS: prdata <= {24'h00_0000, sync_in_progress, 7'h00};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // Plain control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      controlSecond <= RESET_REG8;
      eventControl <= 2'b00;
    end else if (wrDone && regIdx == IDX_CONTROL_SECOND) begin
      controlSecond <= pwdata[7:0];
    end else if (wrDone && regIdx == IDX_EVENT_CONTROL) begin
      eventControl <= pwdata[1:0];
    end
  end

  // One shared enable set, written through set and clear views
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnable <= '0;
    end else if (wrDone && regIdx == IDX_IRQ_ENABLE_SET) begin
      irqEnable <= irqEnable | pwdata[2:0];
    end else if (wrDone && regIdx == IDX_IRQ_ENABLE_CLEAR) begin
      irqEnable <= irqEnable & ~pwdata[2:0];
    end
  end

  // Sticky flags; a hardware set in the same cycle beats a clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlags <= '0;
    end else begin
      if (wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[2]) begin
        irqFlags.sync_done_irq <= 1'b0;
      end
      if ((wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[1]) || bufCommit) begin
        irqFlags.empty <= 1'b0;
      end
      if (wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[0]) begin
        irqFlags.underrun <= 1'b0;
      end
      if (syncState == SY_DONE) begin
        irqFlags.sync_done_irq <= 1'b1;
      end
      if (moveNow) begin
        irqFlags.empty <= 1'b1;
      end
      if (startTaken && !bufFull) begin
        irqFlags.underrun <= 1'b1;
      end
    end
  end

  // Synchronisation sequencer: busy from the write edge to commit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncState <= SY_IDLE;
      syncCnt <= 8'h00;
      pend <= '0;
    end else begin
      unique case (syncState)
        SY_IDLE: begin
          if (wrDone && syncWrite) begin
            syncState <= SY_WAIT;
            syncCnt <= 8'(SYNC_COUNT - 1);
            pend <= '{regIdx == IDX_CONVERSION_VALUE_BUFFER, pwdata[15:0]};
          end
        end
        SY_WAIT: begin
          if (syncCnt == 8'h00) begin
            syncState <= SY_DONE;
          end else begin
            syncCnt <= syncCnt - 8'h01;
          end
        end
        SY_DONE: begin
          syncState <= SY_IDLE;
        end
        // Code 2'b10 is never entered; fall back to idle if it appears
        default: begin
          syncState <= SY_IDLE;
        end
      endcase
    end
  end

  // Conversion value and buffer; an underrun leaves both untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convValue <= RESET_VALUE16;
      bufValue <= RESET_VALUE16;
      bufFull <= 1'b0;
    end else begin
      if (dataCommit) begin
        convValue <= pend.value;
      end else if (moveNow) begin
        convValue <= bufValue;
      end
      if (bufCommit) begin
        bufValue <= pend.value;
        bufFull <= 1'b1;
      end else if (moveNow) begin
        bufFull <= 1'b0;
      end
    end
  end

  // Outputs to the converter, the event system and the interrupt line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dacCode <= '0;
      conversionStart <= 1'b0;
      emptyEvent <= 1'b0;
      irq <= 1'b0;
    end else begin
      dacCode <= pickCode(convValue, controlSecond[LEFT_ALIGN_BIT]);
      conversionStart <= moveNow || dataCommit;
      emptyEvent <= moveNow && eventControl[EMPTY_EVENT_BIT];
      irq <= |(irqFlags & irqEnable);
    end
  end

  // Busy length counter, only read by the checks below
  logic [8:0] busyLen;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyLen <= 9'h000;
    end else if (sync_in_progress) begin
      busyLen <= busyLen + 9'h001;
    end else begin
      busyLen <= 9'h000;
    end
  end

  // Checks
  // Clear view removes only the bits written as one
  enable_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && regIdx == IDX_IRQ_ENABLE_CLEAR |=> irqEnable == ($past(irqEnable) & ~$past(pwdata[2:0])))
    else $error("enable clear write wrong");

  // Enables move only through their two views
  enable_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wrDone && (regIdx == IDX_IRQ_ENABLE_SET || regIdx == IDX_IRQ_ENABLE_CLEAR)) |=> $stable(irqEnable))
    else $error("enables changed without a write");

  // Write-one clears the empty flag unless a move sets it again
  empty_w1c_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[1] && !moveNow |=> !irqFlags.empty)
    else $error("empty flag not cleared by write");

  // Empty flag is sticky until a clear or a buffer write
  empty_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqFlags.empty && !bufCommit && !(wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[1]) |=> irqFlags.empty)
    else $error("empty flag lost");

  // Write-one clears underrun unless a new underrun lands
  underrun_w1c_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[0] && !(startTaken && !bufFull) |=> !irqFlags.underrun)
    else $error("underrun not cleared by write");

  // Underrun stays until software writes one to it
  underrun_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqFlags.underrun && !(wrDone && regIdx == IDX_IRQ_FLAGS && pwdata[0]) |=> irqFlags.underrun)
    else $error("underrun flag lost");

  // No request without an enabled flag
  irq_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(|(irqFlags & irqEnable)) |=> !irq)
    else $error("interrupt without enabled flag");

  // Every buffer move starts a conversion one cycle later
  start_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    moveNow |=> conversionStart)
    else $error("move without conversion start");

  // A start pulse always has a load behind it
  start_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conversionStart |-> $past(moveNow) || $past(dataCommit))
    else $error("stray conversion start");

  // Enabled empty event follows every move
  empty_event_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    moveNow && eventControl[EMPTY_EVENT_BIT] |=> emptyEvent)
    else $error("empty event missing");

  // Right aligned code is the low ten bits
  right_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !controlSecond[LEFT_ALIGN_BIT] |=> dacCode == $past(convValue[CODE_WIDTH-1:0]))
    else $error("right aligned code wrong");

  // Left aligned code is the top ten bits
  left_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    controlSecond[LEFT_ALIGN_BIT] |=> dacCode == $past(convValue[15:LEFT_CODE_LSB]))
    else $error("left aligned code wrong");

  // Buffer commit stores the pending word and marks it new
  buf_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bufCommit |=> bufFull && bufValue == $past(pend.value))
    else $error("buffer commit wrong");

  // Direct write reaches the conversion register only after sync
  data_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dataCommit |=> convValue == $past(pend.value))
    else $error("direct commit wrong");

  // Guarded write is answered with an error
  guard_error_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && pready && pwrite && guarded && $stable(peripheral_write_guard) && $stable(paddr) |-> pslverr)
    else $error("guarded write accepted");

  // Refused enable write leaves the enables alone
  guard_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    access && pready && pslverr && regIdx == IDX_IRQ_ENABLE_SET |=> $stable(irqEnable))
    else $error("refused write changed enables");

  // Busy lasts exactly the sync count plus the commit cycle
  busy_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(sync_in_progress) |-> busyLen == 9'(SYNC_COUNT + 1))
    else $error("sync busy length wrong");

  // Busy never outlives its window
  busy_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_in_progress |-> busyLen <= 9'(SYNC_COUNT))
    else $error("sync busy too long");

  // Commit cycle ends busy and raises sync ready
  sync_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    syncState == SY_DONE |=> !sync_in_progress && irqFlags.sync_done_irq)
    else $error("sync end wrong");

  empty_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqFlags.empty && irqEnable.empty |=> irq)
    else $error("empty flag enabled but no interrupt");
  underrun_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqFlags.underrun && irqEnable.underrun |=> irq)
    else $error("underrun enabled but no interrupt");
  enable_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && regIdx == IDX_IRQ_ENABLE_SET |=> irqEnable == ($past(irqEnable) | $past(pwdata[2:0])))
    else $error("enable set write wrong");
  underrun_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startTaken && !bufFull |=> irqFlags.underrun && $stable(convValue))
    else $error("underrun not flagged");
  empty_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    moveNow |=> irqFlags.empty && convValue == $past(bufValue))
    else $error("buffer move did not set empty");
  empty_event_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emptyEvent |-> $past(moveNow) && $past(eventControl[EMPTY_EVENT_BIT]))
    else $error("stray empty event");
  sync_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDone && syncWrite |=> sync_in_progress [*2])
    else $error("sync busy not raised");
  sync_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sync_in_progress) |-> ##[1:260] !sync_in_progress)
    else $error("sync busy never cleared");
  buf_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bufCommit && !moveNow |=> !irqFlags.empty)
    else $error("buffer write left empty set");
  ignore_event_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startEvent && !eventControl[START_EVENT_BIT] && !dataCommit |=> $stable(convValue))
    else $error("disabled event changed value");
endmodule : ddi_top
`default_nettype wire

// [sim/ddi_event_src.sv]
// Event routing partner: turns a bench request into a one-cycle start event.
// Assumes the bench raises fire for exactly one cycle just after an edge.
`timescale 1ns/1ps
`default_nettype none
module ddi_event_src (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic startEvent
);
  // Registered so the pulse is always a whole clock cycle wide
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startEvent <= 1'b0;
    end else begin
      startEvent <= fire;
    end
  end
endmodule : ddi_event_src
`default_nettype wire

// [sim/test_dac_data_interrupt_regs.sv]
// Self-checking bench for the converter data and interrupt registers.
// Assumes ddi_pkg is compiled first; the design answers APB with wait states.
`timescale 1ns/1ps
`default_nettype none
module test_dac_data_interrupt_regs;
  import ddi_pkg::*;
  localparam int SYNCN = 6;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, guard = 1'b0, fire = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, conversionStart, emptyEvent, irq, startEvent, lastErr;
  logic [9:0] dacCode;
  int failures = 0, checked = 0, starts = 0, empties = 0, s0, e0;
  always #5 ref_clk = ~ref_clk;
  ddi_event_src u_ddi_event_src (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .startEvent(startEvent));
  ddi_top #(.SYNC_COUNT(SYNCN)) u_ddi_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .peripheral_write_guard(guard), .startEvent(startEvent),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dacCode(dacCode), .conversionStart(conversionStart),
    .emptyEvent(emptyEvent), .irq(irq));
  // Pulse counters; one-cycle pulses are seen at every edge
  always @(posedge ref_clk) begin
    if (conversionStart === 1'b1) starts++;
    if (emptyEvent === 1'b1) empties++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      stop_test;
    end
    rdata = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rc(input string w, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(w, rdata, exp);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Start event through the partner, then let the load settle
  task automatic pulse_start;
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    tick(6);
  endtask : pulse_start
  task automatic t_reset;
    rc("enables", IDX_IRQ_ENABLE_SET, 32'h0);
    rc("flags", IDX_IRQ_FLAGS, 32'h0);
    rc("status", IDX_SYNC_STATUS, 32'h0);
    apb(1'b0, 8'h03, 32'h0);
    chk("unmapped err", 32'(lastErr), 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_enables;
    wr(IDX_IRQ_ENABLE_SET, 32'h3);
    rc("clear view", IDX_IRQ_ENABLE_CLEAR, 32'h3);
    wr(IDX_IRQ_ENABLE_SET, 32'h0);
    rc("zero write", IDX_IRQ_ENABLE_SET, 32'h3);
    wr(IDX_IRQ_ENABLE_CLEAR, 32'h1);
    rc("set view", IDX_IRQ_ENABLE_SET, 32'h2);
    guard <= 1'b1;
    wr(IDX_IRQ_ENABLE_SET, 32'h1);
    chk("guard err", 32'(lastErr), 32'h1);
    guard <= 1'b0;
    rc("guarded", IDX_IRQ_ENABLE_SET, 32'h2);
    $display("test enables done");
  endtask : t_enables
  task automatic t_sync;
    wr(IDX_CONVERSION_VALUE_BUFFER, 32'h155);
    rc("busy", IDX_SYNC_STATUS, 32'h80);
    tick(SYNCN + 4);
    rc("idle", IDX_SYNC_STATUS, 32'h0);
    rc("sync flags", IDX_IRQ_FLAGS, 32'h4);
    wr(IDX_IRQ_FLAGS, 32'h7);
    $display("test sync done");
  endtask : t_sync
  task automatic t_event;
    wr(IDX_EVENT_CONTROL, 32'h3);
    s0 = starts;
    pulse_start;
    chk("code", 32'(dacCode), 32'h155);
    chk("starts", 32'(starts - s0), 32'h1);
    chk("empty events", 32'(empties), 32'h1);
    rc("empty flag", IDX_IRQ_FLAGS, 32'h2);
    chk("irq empty", 32'(irq), 32'h1);
    $display("test event done");
  endtask : t_event
  task automatic t_underrun;
    wr(IDX_IRQ_ENABLE_SET, 32'h1);
    wr(IDX_IRQ_ENABLE_CLEAR, 32'h2);
    tick(2);
    chk("irq masked", 32'(irq), 32'h0);
    s0 = starts;
    pulse_start;
    rc("underrun", IDX_IRQ_FLAGS, 32'h3);
    chk("kept code", 32'(dacCode), 32'h155);
    chk("no start", 32'(starts - s0), 32'h0);
    chk("irq underrun", 32'(irq), 32'h1);
    wr(IDX_IRQ_FLAGS, 32'h0);
    rc("zero clear", IDX_IRQ_FLAGS, 32'h3);
    wr(IDX_IRQ_FLAGS, 32'h1);
    rc("one clear", IDX_IRQ_FLAGS, 32'h2);
    tick(2);
    chk("irq low", 32'(irq), 32'h0);
    $display("test underrun done");
  endtask : t_underrun
  task automatic t_left;
    wr(IDX_CONTROL_SECOND, 32'h4);
    wr(IDX_CONVERSION_VALUE_BUFFER, 32'hAAC0);
    tick(SYNCN + 4);
    pulse_start;
    chk("left code", 32'(dacCode), 32'h2AB);
    wr(IDX_IRQ_FLAGS, 32'h4);
    wr(IDX_CONVERSION_VALUE_BUFFER, 32'h8000);
    tick(SYNCN + 4);
    rc("buffer clears", IDX_IRQ_FLAGS, 32'h4);
    $display("test left done");
  endtask : t_left
  task automatic t_off_direct;
    wr(IDX_EVENT_CONTROL, 32'h0);
    s0 = starts;
    pulse_start;
    chk("ignored code", 32'(dacCode), 32'h2AB);
    chk("ignored start", 32'(starts - s0), 32'h0);
    wr(IDX_CONTROL_SECOND, 32'h0);
    wr(IDX_CONVERSION_VALUE, 32'h3FF);
    tick(SYNCN + 4);
    chk("direct code", 32'(dacCode), 32'h3FF);
    chk("direct start", 32'(starts - s0), 32'h1);
    wr(IDX_EVENT_CONTROL, 32'h1);
    s0 = starts;
    e0 = empties;
    pulse_start;
    chk("silent empty", 32'(empties - e0), 32'h0);
    chk("silent start", 32'(starts - s0), 32'h1);
    chk("moved code", 32'(dacCode), 32'h000);
    $display("test direct done");
  endtask : t_off_direct
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Reset for five cycles, then the scenarios in order
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_enables;
    t_sync;
    t_event;
    t_underrun;
    t_left;
    t_off_direct;
    stop_test;
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test;
  end
endmodule : test_dac_data_interrupt_regs
`default_nettype wire
